// [hdl/gpio_ports_with_wakeup.sv]
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module gpio_ports_with_wakeup
  import gpio_wake_pkg::*;
#(
  parameter bit EXT_RESET_OPTION = 1'b0
) (
  input  wire  logic                       mclk,
  input  wire  logic                       resetn,
  input  wire  logic                       lowPower,
  input  wire  gpio_wake_pkg::pins_t       pinIn,
  output       gpio_wake_pkg::pins_t       pinOut,
  output       gpio_wake_pkg::pins_t       pinOe,
  output       gpio_wake_pkg::pins_t       pullupEn,
  output logic                             wakeRequest,
  output logic                             wakeVector,
  output logic                             pin00Vector,
  input  wire  logic [ADDR_W-1:0]          s_axi_awaddr,
  input  wire  logic                       s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire  logic [31:0]                s_axi_wdata,
  input  wire  logic [3:0]                 s_axi_wstrb,
  input  wire  logic                       s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire  logic                       s_axi_bready,
  input  wire  logic [ADDR_W-1:0]          s_axi_araddr,
  input  wire  logic                       s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire  logic                       s_axi_rready
);
  import gpio_wake_pkg::*;

  // fixed fields inside the register words
  localparam int          BOP_BIT_W  = 3;
  localparam int          P16_POS    = 6;
  localparam logic [7:0]  BIT_ONE    = 8'h01;
  localparam logic [23:0] RDATA_FILL = 24'h000000;

  // pin synchronisers: first stage read only by the second
  pins_t pinMeta_q;
  pins_t pinSync_q;
  pins_t pinPrev_q;
  logic  lpMeta_q;
  logic  lpSync_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinPrev_q <= '0;
      lpMeta_q  <= 1'b0;
      lpSync_q  <= 1'b0;
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
      lpMeta_q  <= lowPower;
      lpSync_q  <= lpMeta_q;
    end
  end

  // register state
  logic [7:0] dir0_q;
  logic [7:0] dir1_q;
  logic [7:0] dir5_q;
  logic [7:0] dat0_q;
  logic [7:0] dat1_q;
  logic [7:0] dat5_q;
  logic [7:0] pu0_q;
  logic [7:0] pu1_q;
  logic [7:0] pu5_q;
  logic [7:0] wakeEn_q;
  logic [1:0] edgeSel_q;
  logic       wakeFlag_q;
  logic       wake_interrupt_enable_q;
  logic       p00Flag_q;
  logic       pin00_interrupt_enable_q;

  // axi write channel: address and data latched independently, either order
  logic              awHeld_q;
  logic              wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              doWrite;
  logic [7:0]        wIdx;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wIdx          = awAddr_q[ADDR_W-1:2];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // the bit-op word is listed so it answers OKAY although it reads back zero
  function automatic logic knownIdx(input logic [7:0] idx);
    case (idx)
      IDX_PORT0_DIRECTION, IDX_EDGE_SELECT, IDX_PORT1_WAKE_ENABLE, IDX_PORT1_DIRECTION,
      IDX_PORT5_DIRECTION, IDX_PORT0_DATA, IDX_PORT1_DATA, IDX_PORT5_DATA,
      IDX_PORT0_PULLUP, IDX_PORT1_PULLUP, IDX_PORT5_PULLUP, IDX_IRQ_CONTROL,
      IDX_BIT_OP: knownIdx = 1'b1;
      default: knownIdx = 1'b0;
    endcase
  endfunction : knownIdx

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unmapped words are answered with an error and leave every register alone
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bresp <= knownIdx(wIdx) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // byte write and single-bit operation both resolve into a full next value for each register built on nextVal; edge select and irq control take byte writes only
  logic       lowLane;
  logic       bitOp;
  logic [7:0] bitIdx;
  logic [7:0] bitSel;
  logic       bitVal;

  // a write with neither low strobe bit set is answered but changes nothing
  assign lowLane = doWrite && wStrb_q[0];
  assign bitOp   = doWrite && wIdx == IDX_BIT_OP && wStrb_q[1];
  assign bitIdx  = wData_q[7:0];
  assign bitSel  = BIT_ONE << wData_q[BOP_BIT_LSB +: BOP_BIT_W];
  assign bitVal  = wData_q[BOP_VAL];

  // the mask keeps absent bit positions at zero whatever is written
  function automatic logic [7:0] nextVal(input logic [7:0] cur, input logic [7:0] idx,
                                         input logic [7:0] mask);
    logic [7:0] v;
    v = cur;
    if (lowLane && wIdx == idx) begin
      v = wData_q[7:0];
    end else if (bitOp && bitIdx == idx) begin
      v = bitVal ? (cur | bitSel) : (cur & ~bitSel);
    end
    nextVal = v & mask;
  endfunction : nextVal

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dir0_q <= RST_ZERO;
      dir1_q <= RST_ZERO;
      dir5_q <= RST_ZERO;
    end else begin
      dir0_q <= nextVal(dir0_q, IDX_PORT0_DIRECTION, MASK_P0);
      dir1_q <= nextVal(dir1_q, IDX_PORT1_DIRECTION, MASK_P1);
      dir5_q <= nextVal(dir5_q, IDX_PORT5_DIRECTION, MASK_P5);
    end
  end

  // p1.6 pinned high when the external reset option holds it
  localparam logic [7:0] P16_FORCE = EXT_RESET_OPTION ? (BIT_ONE << P16_POS) : RST_ZERO;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dat0_q <= RST_ZERO;
      dat1_q <= RST_ZERO | P16_FORCE;
      dat5_q <= RST_ZERO;
    end else begin
      dat0_q <= nextVal(dat0_q, IDX_PORT0_DATA, MASK_P0);
      dat1_q <= nextVal(dat1_q, IDX_PORT1_DATA, MASK_P1) | P16_FORCE;
      dat5_q <= nextVal(dat5_q, IDX_PORT5_DATA, MASK_P5);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pu0_q <= RST_ZERO;
      pu1_q <= RST_ZERO;
      pu5_q <= RST_ZERO;
    end else begin
      pu0_q <= nextVal(pu0_q, IDX_PORT0_PULLUP, MASK_P0);
      pu1_q <= nextVal(pu1_q, IDX_PORT1_PULLUP, MASK_P1);
      pu5_q <= nextVal(pu5_q, IDX_PORT5_PULLUP, MASK_P5);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wakeEn_q  <= RST_ZERO;
      edgeSel_q <= RST_EDGE;
    end else begin
      wakeEn_q <= nextVal(wakeEn_q, IDX_PORT1_WAKE_ENABLE, MASK_P1);
      // codes are stored as written; the reserved code simply disables the trigger
      if (lowLane && wIdx == IDX_EDGE_SELECT) begin
        edgeSel_q <= wData_q[1:0];
      end
    end
  end

  // event detection on synchronised pins
  logic p00Rise;
  logic p00Fall;
  logic p00Trig;
  logic p1Change;
  logic p0Change;
  logic wakeEvent;

  assign p00Rise  = pinSync_q.port0[0] && !pinPrev_q.port0[0];
  assign p00Fall  = !pinSync_q.port0[0] && pinPrev_q.port0[0];
  always_comb begin
    case (edgeSel_q)
      EDGE_RISE: p00Trig = p00Rise;
      EDGE_FALL: p00Trig = p00Fall;
      EDGE_BOTH: p00Trig = p00Rise || p00Fall;
      default:   p00Trig = 1'b0;                            // reserved code: no trigger
    endcase
  end

  // only input pins count; a driven pin would wake itself
  assign p1Change  = |((pinSync_q.port1 ^ pinPrev_q.port1) & wakeEn_q[P1_W-1:0]
                       & ~dir1_q[P1_W-1:0]);
  assign p0Change  = |((pinSync_q.port0 ^ pinPrev_q.port0) & ~dir0_q[P0_W-1:0]);
  assign wakeEvent = lpSync_q && (p1Change || p0Change);
  // one-cycle pulse: the power controller outside must latch it
  assign wakeRequest = wakeEvent;

  // flags: set wins over a software clear in the same cycle
  logic irqWrite;
  assign irqWrite = lowLane && wIdx == IDX_IRQ_CONTROL;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wakeFlag_q <= 1'b0;
      p00Flag_q  <= 1'b0;
    end else begin
      if (wakeEvent) begin
        wakeFlag_q <= 1'b1;
      end else if (irqWrite) begin
        wakeFlag_q <= wData_q[IRQC_WAKE_FLAG];
      end
      if (p00Trig) begin
        p00Flag_q <= 1'b1;
      end else if (irqWrite) begin
        p00Flag_q <= wData_q[IRQC_P00_FLAG];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wake_interrupt_enable_q <= 1'b0;
      pin00_interrupt_enable_q  <= 1'b0;
    end else if (irqWrite) begin
      wake_interrupt_enable_q <= wData_q[IRQC_WAKE_IEN];
      pin00_interrupt_enable_q  <= wData_q[IRQC_P00_IEN];
    end
  end

  // enables only gate the vector outputs; flags set regardless
  assign wakeVector  = wakeFlag_q && wake_interrupt_enable_q;
  assign pin00Vector = p00Flag_q && pin00_interrupt_enable_q;

  // pad drive from registers
  // pull-ups stay enabled on output pins; the pad ignores them while driving
  always_comb begin
    pinOut.port0   = dat0_q[P0_W-1:0];
    pinOut.port1   = dat1_q[P1_W-1:0];
    pinOut.port5   = dat5_q[P5_W-1:0];
    pinOe.port0    = dir0_q[P0_W-1:0];
    pinOe.port1    = dir1_q[P1_W-1:0];
    pinOe.port5    = dir5_q[P5_W-1:0];
    pullupEn.port0 = pu0_q[P0_W-1:0];
    pullupEn.port1 = pu1_q[P1_W-1:0];
    pullupEn.port5 = pu5_q[P5_W-1:0];
  end

  // read channel, one-cycle latency
  logic [7:0] rIdx;
  logic [7:0] rByte;
  logic       rKnown;
  assign rIdx = s_axi_araddr[ADDR_W-1:2];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rKnown = 1'b1;
    case (rIdx)
      IDX_PORT0_DIRECTION:   rByte = dir0_q;
      IDX_EDGE_SELECT:       rByte = {6'h00, edgeSel_q};
      IDX_PORT1_WAKE_ENABLE: rByte = wakeEn_q;
      IDX_PORT1_DIRECTION:   rByte = dir1_q;
      IDX_PORT5_DIRECTION:   rByte = dir5_q;
      IDX_PORT0_DATA:        rByte = {5'h00, pinSync_q.port0};
      IDX_PORT1_DATA:        rByte = {1'b0, pinSync_q.port1} | P16_FORCE;
      IDX_PORT5_DATA:        rByte = {4'h0, pinSync_q.port5};
      IDX_IRQ_CONTROL:       rByte = {4'h0, pin00_interrupt_enable_q, p00Flag_q, wake_interrupt_enable_q, wakeFlag_q};
      IDX_PORT0_PULLUP, IDX_PORT1_PULLUP, IDX_PORT5_PULLUP,
      IDX_BIT_OP:            rByte = RST_ZERO;              // write-only: reads zero
      default: begin
        rByte  = RST_ZERO;
        rKnown = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // data captured at the accept edge so it stands unchanged until rready
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= {RDATA_FILL, rByte};
      s_axi_rresp <= rKnown ? RESP_OKAY : RESP_SLVERR;
    end
  end

endmodule : gpio_ports_with_wakeup

// [hdl/gpio_wake_pkg.sv]
package gpio_wake_pkg;

  // register index = printed offset; byte address = 4 * index
  localparam logic [7:0] IDX_PORT0_DIRECTION   = 8'hB8;
  localparam logic [7:0] IDX_EDGE_SELECT       = 8'hBF;
  localparam logic [7:0] IDX_PORT1_WAKE_ENABLE = 8'hC0;
  localparam logic [7:0] IDX_PORT1_DIRECTION   = 8'hC1;
  localparam logic [7:0] IDX_PORT5_DIRECTION   = 8'hC5;
  localparam logic [7:0] IDX_PORT0_DATA        = 8'hD0;
  localparam logic [7:0] IDX_PORT1_DATA        = 8'hD1;
  localparam logic [7:0] IDX_PORT5_DATA        = 8'hD5;
  localparam logic [7:0] IDX_PORT0_PULLUP      = 8'hE0;
  localparam logic [7:0] IDX_PORT1_PULLUP      = 8'hE1;
  localparam logic [7:0] IDX_PORT5_PULLUP      = 8'hE5;
  localparam logic [7:0] IDX_IRQ_CONTROL       = 8'hF0;
  localparam logic [7:0] IDX_BIT_OP            = 8'hF1;

  localparam int ADDR_W = 10;
  localparam int P0_W   = 3;
  localparam int P1_W   = 7;
  localparam int P5_W   = 4;

  localparam logic [7:0] MASK_P0 = 8'h07;
  localparam logic [7:0] MASK_P1 = 8'h7F;
  localparam logic [7:0] MASK_P5 = 8'h0F;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_EDGE = 2'h2;

  // edge select encoding for pin 0.0
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // irq control register fields
  localparam int IRQC_WAKE_FLAG = 0;
  localparam int IRQC_WAKE_IEN  = 1;
  localparam int IRQC_P00_FLAG  = 2;
  localparam int IRQC_P00_IEN   = 3;

  // bit operation register fields: [7:0] register index, [10:8] bit, [11] value
  localparam int BOP_BIT_LSB = 8;
  localparam int BOP_VAL     = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [P0_W-1:0] port0;
    logic [P1_W-1:0] port1;
    logic [P5_W-1:0] port5;
  } pins_t;

endpackage : gpio_wake_pkg

// [tb/gpio_pin_model.sv]
`timescale 1ns/1ps
module gpio_pin_model
  import gpio_wake_pkg::*;
(
  input wire logic                 mclk,
  input wire gpio_wake_pkg::pins_t pinOut,
  input wire gpio_wake_pkg::pins_t pinOe,
  input wire gpio_wake_pkg::pins_t pullupEn,
  input wire gpio_wake_pkg::pins_t extDrv,
  input wire gpio_wake_pkg::pins_t extEn,
  output gpio_wake_pkg::pins_t     pinLevel
);
  // a floating pad wanders each cycle, so nobody may count on its level
  logic [13:0] noise_q = 14'h2AAA;
  always_ff @(posedge mclk) begin
    noise_q <= ~noise_q;
  end
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      if (pinOe[i]) pinLevel[i] = pinOut[i];
      else if (extEn[i]) pinLevel[i] = extDrv[i];
      else pinLevel[i] = pullupEn[i] | noise_q[i];
    end
  end
endmodule : gpio_pin_model

// [tb/gpio_ports_with_wakeup_monitor.sv]
`timescale 1ns/1ps
module gpio_ports_with_wakeup_monitor
  import gpio_wake_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 lowPower,
  input wire gpio_wake_pkg::pins_t pinOut,
  input wire gpio_wake_pkg::pins_t pinOe,
  input wire gpio_wake_pkg::pins_t pullupEn,
  input wire logic                 wakeRequest,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  pad_ctrl_a: assert property ($changed({pinOut, pinOe, pullupEn}) |-> $rose(s_axi_bvalid))
    else $error("pad control changed without a write");
  wake_lowpwr_a: assert property (wakeRequest |-> $past(lowPower, 2) || $past(lowPower, 3))
    else $error("wake outside low power");
endmodule : gpio_ports_with_wakeup_monitor

bind gpio_ports_with_wakeup gpio_ports_with_wakeup_monitor mon_u (.*);

// [tb/gpio_ports_with_wakeup_test.sv]
`timescale 1ns/1ps
module gpio_ports_with_wakeup_test;
  import gpio_wake_pkg::*;
  logic mclk, resetn, lowPower, wakeRequest, wakeVector, pin00Vector;
  pins_t pinIn, pinOut, pinOe, pullupEn, extDrv, extEn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_total = 0;
  int checks_done = 0;
  int wakePulses = 0;
  pins_t optOut;
  logic [31:0] optRdata;
  localparam logic [7:0] CFG_IDX [7] = '{IDX_PORT0_DIRECTION, IDX_PORT1_WAKE_ENABLE,
    IDX_PORT1_DIRECTION, IDX_PORT5_DIRECTION, IDX_PORT0_PULLUP, IDX_PORT1_PULLUP,
    IDX_PORT5_PULLUP};
  localparam logic [7:0] CFG_MSK [7] = '{MASK_P0, MASK_P1, MASK_P1, MASK_P5, 8'h00, 8'h00,
    8'h00};

  gpio_ports_with_wakeup dut_u (.*);
  gpio_pin_model pad_u (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
    .extDrv(extDrv), .extEn(extEn), .pinLevel(pinIn));
  // same bus traffic as dut_u, built with the external-reset option on
  gpio_ports_with_wakeup #(.EXT_RESET_OPTION(1'b1)) optDut_u (.mclk(mclk), .resetn(resetn),
    .lowPower(lowPower), .pinIn(pinIn), .pinOut(optOut), .pinOe(), .pullupEn(),
    .wakeRequest(), .wakeVector(), .pin00Vector(), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_rdata(optRdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready));

  always @(posedge mclk) begin
    if (wakeRequest === 1'b1) wakePulses <= wakePulses + 1;
  end

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s = 4'h1,
                    input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                    input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge mclk);
  endtask : rd

  // pin settles through the synchroniser and the flag logic within 3 edges
  task automatic pin(input logic [3:0] b, input logic v);
    extDrv[b] <= v;
    repeat (5) @(posedge mclk);
  endtask : pin

  task automatic final_report;
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    lowPower = 1'b0;
    extDrv = '0;
    extEn = '1;
    extEn.port5 = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(IDX_EDGE_SELECT, {6'h0, RST_EDGE});
    for (int i = 0; i < 7; i++) begin
      rd(CFG_IDX[i], 8'h00);
      wr(CFG_IDX[i], 32'hFF);
      rd(CFG_IDX[i], CFG_MSK[i]);
    end
    chk(32'(pinOe), 32'h3FFF);
    chk(32'(pullupEn), 32'h3FFF);
    wr(IDX_PORT0_DATA, 32'hFF);
    wr(IDX_PORT1_DATA, 32'hFF);
    wr(IDX_PORT5_DATA, 32'hFF);
    chk(32'(pinOut), 32'h3FFF);
    rd(IDX_PORT1_DATA, MASK_P1);
    wr(IDX_BIT_OP, {20'h0, 1'b0, 3'h3, IDX_PORT1_DATA}, 4'h2);
    chk(32'(pinOut), 32'h3F7F);
    wr(IDX_BIT_OP, {20'h0, 1'b0, 3'h2, IDX_PORT1_DIRECTION}, 4'h2);
    rd(IDX_PORT1_DIRECTION, 8'h7B);
    wr(IDX_BIT_OP, {20'h0, 1'b1, 3'h2, IDX_PORT1_DIRECTION}, 4'h2);
    rd(IDX_PORT1_DIRECTION, 8'h7F);
    wr(8'h10, 32'h00, 4'h1, RESP_SLVERR);
    rd(8'h10, 8'h00, RESP_SLVERR);
    chk(32'(pinOut), 32'h3F7F);
    wr(IDX_PORT0_DIRECTION, 32'h00);
    wr(IDX_PORT1_DIRECTION, 32'h00);
    wr(IDX_PORT5_DIRECTION, 32'h00);
    extDrv.port1 <= 7'h55;
    repeat (5) @(posedge mclk);
    rd(IDX_PORT1_DATA, 8'h55);
    // code 00 is reserved and must never trigger
    for (logic [2:0] e = 3'h0; e < 3'h4; e++) begin
      wr(IDX_IRQ_CONTROL, 32'h00);
      wr(IDX_EDGE_SELECT, 32'(e));
      pin(4'hB, 1'b1);
      rd(IDX_IRQ_CONTROL, {5'h0, e[0], 2'h0});
      wr(IDX_IRQ_CONTROL, 32'h00);
      pin(4'hB, 1'b0);
      rd(IDX_IRQ_CONTROL, {5'h0, e[1], 2'h0});
    end
    pin(4'hB, 1'b1);
    chk(32'(pin00Vector), 32'h0);
    wr(IDX_IRQ_CONTROL, 32'h0C);
    chk(32'(pin00Vector), 32'h1);
    extDrv.port1 <= 7'h00;
    wr(IDX_IRQ_CONTROL, 32'h00);
    wr(IDX_PORT1_WAKE_ENABLE, 32'h01);
    lowPower <= 1'b1;
    repeat (4) @(posedge mclk);
    pin(4'h5, 1'b1);
    rd(IDX_IRQ_CONTROL, 8'h00);
    pin(4'h4, 1'b1);
    rd(IDX_IRQ_CONTROL, 8'h01);
    chk(32'(wakeVector), 32'h0);
    wr(IDX_IRQ_CONTROL, 32'h02);
    pin(4'hC, 1'b1);
    rd(IDX_IRQ_CONTROL, 8'h03);
    chk(32'(wakeVector), 32'h1);
    wr(IDX_PORT1_DATA, 32'h00);
    chk(32'(pinOut.port1), 32'h00);
    chk(32'(optOut.port1), 32'h40);
    rd(IDX_PORT1_DATA, 8'h03);
    chk(optRdata, 32'h43);
    chk(32'(wakePulses), 32'h2);
    final_report();
  end
endmodule : gpio_ports_with_wakeup_test
